// ==== rtl/gaf_port.sv ====
// Purpose: Port lines 14..23 with indicators, interrupts and strap funcs
// Assumes: One 10 MHz clock; pins and ring input are asynchronous
// Notes:   Index 0 of every line vector is line 14
// Function
// - High-speed indicator low when data rate >= 19,200 or fax 14,400.
// - In serial mode each indicator can move to any port line.
// - In plug-and-play mode line 14 is host address bit 15.
// - Line 16 acts as auxiliary serial receive input when selected.
// - Line 17 drives auxiliary serial transmit output when selected.
// - Each external interrupt input can raise a processor interrupt.
// - Interrupt sense: rising, falling, both edges, high or low level.
// - Optional acknowledge on line 20 after interrupt 0.
// - Optional acknowledge on line 21 after interrupt 1.
// - Unused interrupt lines behave as ordinary port lines.
// - Error-correction indicator low in error-correction mode.
// - Test-mode indicator low while any test mode runs.
// - Wait input selected holds the external bus cycle while asserted.
// - Stop input low enters stop mode; high powers back up.
// - In stop mode the pins hold their drive; all other logic keeps running.
// - A buffered processor clock is driven on its own pin.
// - Ring input from line interface is monitored for rings.
// - Auto-answer indicator low while answer count setting non-zero.
`timescale 1ns/1ps

module gaf_port
    import gaf_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_b_in,
    // Register port
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [31:0]       reg_rdata_out,
    // Controller side
    input  wire gaf_modem_t        modem_in,
    input  wire logic              aux_serial_tx_in,
    output logic                   aux_serial_rx_out,
    output logic                   host_addr_bit15_out,
    output logic      [1:0]        irq_out,
    output logic                   eb_hold_out,
    output logic                   stop_mode_out,
    output logic                   ring_detect_out,
    // Pins
    input  wire logic [GP_LINES-1:0] gp_line_in,
    output logic      [GP_LINES-1:0] gp_line_out,
    output logic      [GP_LINES-1:0] gp_line_oe_out,
    input  wire logic              ring_n_in,
    output logic                   cpu_clk_buf_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Sense match for one interrupt input
    function automatic logic sense_hit(input logic [2:0] m,
                                       input logic cur,
                                       input logic prv);
        logic h;
        h = 1'b0;
        case (gaf_sense_t'(m))
            SNS_RISE: h = cur & ~prv;
            SNS_FALL: h = ~cur & prv;
            SNS_BOTH: h = cur ^ prv;
            SNS_HIGH: h = cur;
            SNS_LOW:  h = ~cur;
            default:  h = 1'b0;
        endcase
        return h;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    gaf_state_t st;
    gaf_state_t next_st;
    logic       stopping;
    logic [3:0] ind_on;
    logic [1:0] trig;
    logic [1:0] pclr;
    logic       drv;
    logic       val;
    logic       wr_pend;

    // Buffered processor clock straight to its pin
    assign cpu_clk_buf_out = ref_clk_in;

    // Outputs straight from state
    assign reg_rdata_out       = st.rdata;
    assign gp_line_out         = st.pin_out;
    assign gp_line_oe_out      = st.pin_oe;
    assign host_addr_bit15_out = st.haddr15;
    assign aux_serial_rx_out   = st.rx;
    assign irq_out             = st.irq;
    assign eb_hold_out         = st.hold;
    assign stop_mode_out       = st.stop;
    assign ring_detect_out     = st.ring_det;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        drv = 1'b0;
        val = 1'b1;
        // Two-stage sync, third stage for edges
        next_st.s1 = gp_line_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.rs = {st.rs[1:0], ring_n_in};
        // Stop level on line 23
        stopping = st.alt[L_STOP] & ~st.s2[L_STOP];
        next_st.stop = stopping;
        // Indicator conditions
        ind_on[IND_HS] = (!modem_in.fax_mode
                          && modem_in.link_rate >= HS_DATA_BPS)
                         || (modem_in.fax_mode
                          && modem_in.fax_rate == HS_FAX_BPS);
        ind_on[IND_EC] = modem_in.ec_mode;
        ind_on[IND_TM] = modem_in.test_mode;
        ind_on[IND_AA] = |modem_in.answer_count_setting;
        // Interrupt detection, only when the function is selected
        for (int k = 0; k < 2; k++)
        begin
            trig[k] = st.alt[L_IRQ0+k]
                      & sense_hit(st.irq_cfg[k*3 +: 3],
                                  st.s2[L_IRQ0+k],
                                  st.s3[L_IRQ0+k]);
        end
        // Register writes
        wr_pend = reg_wr_in && reg_addr_in == REG_PEND;
        pclr = wr_pend ? reg_wdata_in[1:0] : 2'h0;
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                REG_MODE:    next_st.mode    = reg_wdata_in[1:0];
                REG_DIR:     next_st.dir     = reg_wdata_in[9:0];
                REG_OUT:     next_st.outv    = reg_wdata_in[9:0];
                REG_ALT:     next_st.alt     = reg_wdata_in[9:0];
                REG_IND_EN:  next_st.ind_en  = reg_wdata_in[3:0];
                REG_IND_IDX: next_st.ind_idx = reg_wdata_in[15:0];
                REG_IRQ_CFG: next_st.irq_cfg = reg_wdata_in[9:0];
                default:     ;
            endcase
        end
        // Pending flags: set wins over clear
        next_st.pend = (st.pend & ~pclr) | trig;
        // Interrupt request registered beside its pending flag
        next_st.irq = next_st.pend & next_st.alt[L_IRQ0+1:L_IRQ0];
        // Ring: falling edge of synced input
        next_st.ring_det = ~st.rs[1] & st.rs[2];
        next_st.ring_flag = (st.ring_flag
                             & ~(reg_wr_in && reg_addr_in == REG_STAT
                                 && reg_wdata_in[0]))
                            | next_st.ring_det;
        // Read data, valid only the cycle after the strobe
        next_st.rdata = 32'h0;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                REG_MODE:    next_st.rdata = {30'h0, st.mode};
                REG_DIR:     next_st.rdata = {22'h0, st.dir};
                REG_OUT:     next_st.rdata = {22'h0, st.outv};
                REG_PIN:     next_st.rdata = {22'h0, st.s2};
                REG_ALT:     next_st.rdata = {22'h0, st.alt};
                REG_IND_EN:  next_st.rdata = {28'h0, st.ind_en};
                REG_IND_IDX: next_st.rdata = {16'h0, st.ind_idx};
                REG_IRQ_CFG: next_st.rdata = {22'h0, st.irq_cfg};
                REG_PEND:    next_st.rdata = {30'h0, st.pend};
                REG_STAT:    next_st.rdata = {26'h0, ind_on,
                                              st.stop, st.ring_flag};
                default:     next_st.rdata = 32'h0;
            endcase
        end
        // Pin drive; frozen while stopped
        if (!stopping)
        begin
            for (int i = 0; i < GP_LINES; i++)
            begin
                drv = st.dir[i];
                val = st.outv[i];
                for (int k = 0; k < 4; k++)
                begin
                    if (st.mode[MODE_SERIAL] && st.ind_en[k]
                        && st.ind_idx[k*4 +: 4] == 4'(i))
                    begin
                        drv = 1'b1;
                        val = ~ind_on[k];
                    end
                end
                if (i == L_TX && st.alt[L_TX])
                begin
                    drv = 1'b1;
                    val = aux_serial_tx_in;
                end
                if ((i == L_ACK0 || i == L_ACK0 + 1)
                    && st.alt[i-2] && st.irq_cfg[CFG_ACK0+i-L_ACK0])
                begin
                    drv = 1'b1;
                    val = st.pend[i-L_ACK0];
                end
                if ((i == L_HADDR && st.mode[MODE_PNP])
                    || ((i == L_RX || i == L_IRQ0 || i == L_IRQ0 + 1
                         || i == L_WAIT || i == L_STOP) && st.alt[i]))
                begin
                    drv = 1'b0;
                end
                next_st.pin_oe[i]  = drv;
                next_st.pin_out[i] = val;
            end
        end
        // Alternate-function inputs to the controller
        next_st.haddr15 = st.mode[MODE_PNP] & st.s2[L_HADDR];
        next_st.rx = st.alt[L_RX] ? st.s2[L_RX] : 1'b1;
        next_st.hold = st.alt[L_WAIT] & ~st.s2[L_WAIT];
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st         <= '0;
            st.ind_idx <= IND_IDX_RST;
            st.outv    <= LINE_RST;
            st.s1      <= LINE_RST;
            st.s2      <= LINE_RST;
            st.s3      <= LINE_RST;
            st.rs      <= 3'h7;
            st.pin_out <= LINE_RST;
            st.rx      <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence hs_on_line0;
        st.mode[MODE_SERIAL] && st.ind_en[IND_HS]
        && st.ind_idx[3:0] == 4'h0 && !stopping && ind_on[IND_HS];
    endsequence

    sequence rise_irq0;
        st.alt[L_IRQ0] && st.irq_cfg[2:0] == 3'h0
        && !gp_line_in[L_IRQ0] ##1 gp_line_in[L_IRQ0] [*3];
    endsequence

    hs_indicator_a: assert property (
        hs_on_line0 |=> !gp_line_out[0] && gp_line_oe_out[0])
        else $error("high-speed indicator not low");

    ec_indicator_a: assert property (
        st.mode[MODE_SERIAL] && st.ind_en[IND_EC] && !stopping
        && !modem_in.ec_mode && st.ind_idx[7:4] == 4'h6
        |=> gp_line_out[6])
        else $error("error-correction indicator not high");

    tm_indicator_a: assert property (
        st.mode[MODE_SERIAL] && st.ind_en[IND_TM] && !stopping
        && modem_in.test_mode && st.ind_idx[11:8] == 4'h7
        |=> !gp_line_out[7])
        else $error("test indicator not low");

    pnp_addr_a: assert property (
        st.mode[MODE_PNP] && !stopping
        |=> !gp_line_oe_out[L_HADDR]
            && host_addr_bit15_out == $past(st.s2[L_HADDR]))
        else $error("address bit line misbehaves");

    tx_follow_a: assert property (
        st.alt[L_TX] && !stopping
        |=> gp_line_out[L_TX] == $past(aux_serial_tx_in))
        else $error("aux transmit not following");

    irq_pend_a: assert property (
        rise_irq0 |=> st.pend[0] && irq_out[0])
        else $error("rising edge not pending");

    ack_line_a: assert property (
        st.alt[L_IRQ0] && st.irq_cfg[CFG_ACK0] && !stopping
        |=> gp_line_out[L_ACK0] == $past(st.pend[0]))
        else $error("acknowledge line wrong");

    stop_entry_a: assert property (
        st.alt[L_STOP] && !gp_line_in[L_STOP] [*3] |=> stop_mode_out)
        else $error("stop mode not entered");

    stop_freeze_a: assert property (
        stopping |=> $stable(gp_line_out) && $stable(gp_line_oe_out))
        else $error("pins moved in stop mode");

endmodule

// ==== rtl/gaf_pkg.sv ====
// Purpose: Shared constants and types for the alternate-function port
// Assumes: Ten port lines, index 0 is line 14, index 9 is line 23
// Notes:   Register offsets are byte addresses on the plain register port
package gaf_pkg;

    // ----------------------------------------------------------------
    // Port geometry and line positions
    // ----------------------------------------------------------------
    localparam int GP_LINES = 10;
    localparam int L_HADDR  = 0;  // Line 14
    localparam int L_RX     = 2;  // Line 16
    localparam int L_TX     = 3;  // Line 17
    localparam int L_IRQ0   = 4;  // Line 18
    localparam int L_ACK0   = 6;  // Line 20
    localparam int L_WAIT   = 8;  // Line 22
    localparam int L_STOP   = 9;  // Line 23

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_DIR     = 8'h04;
    localparam logic [7:0] REG_OUT     = 8'h08;
    localparam logic [7:0] REG_PIN     = 8'h0C;
    localparam logic [7:0] REG_ALT     = 8'h10;
    localparam logic [7:0] REG_IND_EN  = 8'h14;
    localparam logic [7:0] REG_IND_IDX = 8'h18;
    localparam logic [7:0] REG_IRQ_CFG = 8'h1C;
    localparam logic [7:0] REG_PEND    = 8'h20;
    localparam logic [7:0] REG_STAT    = 8'h24;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int MODE_SERIAL = 0;
    localparam int MODE_PNP    = 1;
    localparam int CFG_ACK0    = 8;
    localparam int IND_HS      = 0;
    localparam int IND_EC      = 1;
    localparam int IND_TM      = 2;
    localparam int IND_AA      = 3;
    localparam logic [15:0] IND_IDX_RST = 16'h1760;
    localparam logic [9:0]  LINE_RST    = 10'h3FF; // Lines idle high
    localparam logic [15:0] HS_DATA_BPS = 16'h4B00; // 19,200 bps
    localparam logic [15:0] HS_FAX_BPS  = 16'h3840; // 14,400 bps

    // Interrupt input sensitivity
    typedef enum logic [2:0] {
        SNS_RISE, SNS_FALL, SNS_BOTH, SNS_HIGH, SNS_LOW
    } gaf_sense_t;

    // Modem condition inputs from the controller
    typedef struct packed {
        logic [15:0] link_rate;
        logic [15:0] fax_rate;
        logic        fax_mode;
        logic        ec_mode;
        logic        test_mode;
        logic [7:0]  answer_count_setting;
    } gaf_modem_t;

    // Whole block state
    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0]  mode;
        logic [9:0]  dir;
        logic [9:0]  outv;
        logic [9:0]  alt;
        logic [3:0]  ind_en;
        logic [15:0] ind_idx;
        logic [9:0]  irq_cfg;
        logic [1:0]  pend;
        logic [1:0]  irq;
        logic        ring_flag;
        logic [9:0]  s1;
        logic [9:0]  s2;
        logic [9:0]  s3;
        logic [2:0]  rs;
        logic [9:0]  pin_out;
        logic [9:0]  pin_oe;
        logic        haddr15;
        logic        rx;
        logic        hold;
        logic        stop;
        logic        ring_det;
    } gaf_state_t;

endpackage

// ==== bench/gaf_far_side.sv ====
// Purpose: Far side of the port lines: pull-ups, peripherals, ring
// Assumes: Every port line has a pull-up to the supply
// Notes:   The bench asks for each external drive through the inputs
`timescale 1ns/1ps

module gaf_far_side
    import gaf_pkg::*;
(
    // Block side of the pins
    input  wire logic [GP_LINES-1:0] line_out_in,
    input  wire logic [GP_LINES-1:0] line_oe_in,
    output logic      [GP_LINES-1:0] pin_lvl_out,
    // Requests from the bench
    input  wire logic [GP_LINES-1:0] ext_val_in,
    input  wire logic [GP_LINES-1:0] ext_en_in,
    input  wire logic                wait_req_in,
    input  wire logic                ring_req_in,
    output logic                     ring_n_out
);
    // Resolve each wire; an undriven line rises to its pull-up
    always_comb
    begin
        for (int i = 0; i < GP_LINES; i++)
        begin
            pin_lvl_out[i] = ext_en_in[i] ? ext_val_in[i] : 1'b1;
            if (line_oe_in[i])
                pin_lvl_out[i] = line_out_in[i];
        end
        if (wait_req_in && !line_oe_in[L_WAIT])
            pin_lvl_out[L_WAIT] = 1'b0;
        ring_n_out = ~ring_req_in;
    end
endmodule

// ==== bench/gaf_port_test.sv ====
// Purpose: Self-checking bench for the alternate-function port
// Assumes: 10 MHz clock; far side modelled with pull-ups
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps

module gaf_port_test
    import gaf_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic        ref_clk_in;
    logic        rst_b_in;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    gaf_modem_t  modem;
    logic        tx;
    logic        rx;
    logic        host_addr_bit15;
    logic        hold;
    logic        stop;
    logic        ring_det;
    logic        clk_buf;
    logic        ring_n;
    logic        wait_req;
    logic        ring_req;
    logic [1:0]  irq;
    logic [9:0]  pin_lvl;
    logic [9:0]  line_out;
    logic [9:0]  line_oe;
    logic [9:0]  ext_val;
    logic [9:0]  ext_en;
    logic        v0;
    int          error_cnt;
    int          comparisons;
    int          ring_seen;

    gaf_port dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .modem_in(modem), .aux_serial_tx_in(tx), .aux_serial_rx_out(rx),
        .host_addr_bit15_out(host_addr_bit15), .irq_out(irq), .eb_hold_out(hold),
        .stop_mode_out(stop), .ring_detect_out(ring_det),
        .gp_line_in(pin_lvl), .gp_line_out(line_out),
        .gp_line_oe_out(line_oe), .ring_n_in(ring_n),
        .cpu_clk_buf_out(clk_buf));

    gaf_far_side far_u (.line_out_in(line_out), .line_oe_in(line_oe),
        .pin_lvl_out(pin_lvl), .ext_val_in(ext_val), .ext_en_in(ext_en),
        .wait_req_in(wait_req), .ring_req_in(ring_req),
        .ring_n_out(ring_n));

    // Clock and ring pulse counter
    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in)
        if (ring_det === 1'b1)
            ring_seen++;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr    <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd   <= 1'b0;
        @(posedge ref_clk_in);
        chk(what, exp, reg_rdata);
    endtask
    task automatic ind_step(input gaf_modem_t m, input logic [3:0] exp);
        modem <= m;
        tick(3);
        chk("ind", 32'(exp), 32'({line_out[7:6], line_out[1:0]}));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("pins", 32'h3FF, 32'(line_out));
        chk("oe", 32'h0, 32'(line_oe));
        bus_rd(REG_OUT, 32'h3FF, "out");
        bus_rd(REG_IND_IDX, 32'h1760, "idx");
        bus_rd(8'h3C, 32'h0, "unmapped");
    endtask
    task automatic t_plain();
        bus_wr(REG_DIR, 32'h3FF);
        bus_wr(REG_OUT, 32'h2A5);
        tick(2);
        chk("pins", 32'h2A5, 32'(line_out));
        chk("oe", 32'h3FF, 32'(line_oe));
        bus_wr(REG_DIR, 32'h0);
        bus_wr(REG_OUT, 32'h3FF);
        ext_en  <= 10'h3FF;
        ext_val <= 10'h15A;
        tick(5);
        bus_rd(REG_PIN, 32'h15A, "pin in");
        ext_en  <= 10'h0;
    endtask
    task automatic t_ind();
        bus_wr(REG_MODE, 32'h1);
        bus_wr(REG_IND_EN, 32'hF);
        ind_step('{16'h4AFF, 16'h0, 1'b0, 1'b0, 1'b0, 8'h0}, 4'hF);
        chk("ind oe", 32'hF, 32'({line_oe[7:6], line_oe[1:0]}));
        ind_step('{HS_DATA_BPS, 16'h0, 1'b0, 1'b0, 1'b0, 8'h0}, 4'hE);
        ind_step('{16'h4AFF, HS_FAX_BPS, 1'b1, 1'b0, 1'b0, 8'h0}, 4'hE);
        ind_step('{16'h4AFF, 16'h2580, 1'b1, 1'b0, 1'b0, 8'h0}, 4'hF);
        ind_step('{16'h0, 16'h0, 1'b0, 1'b1, 1'b0, 8'h0}, 4'hB);
        ind_step('{16'h0, 16'h0, 1'b0, 1'b0, 1'b1, 8'h0}, 4'h7);
        ind_step('{16'h0, 16'h0, 1'b0, 1'b0, 1'b0, 8'h1}, 4'hD);
        bus_wr(REG_IND_IDX, 32'h1765);
        ind_step('{HS_DATA_BPS, 16'h0, 1'b0, 1'b0, 1'b0, 8'h0}, 4'hF);
        chk("moved", 32'h2, 32'({line_oe[5], line_out[5]}));
        modem <= '0;
        bus_wr(REG_MODE, 32'h0);
        tick(3);
        chk("ind off", 32'h0, 32'(line_oe));
    endtask
    task automatic t_alt();
        bus_wr(REG_MODE, 32'h2);
        bus_wr(REG_ALT, 32'h00C);
        ext_en  <= 10'h005;
        ext_val <= 10'h001;
        tx      <= 1'b0;
        tick(5);
        chk("haddr", 32'h1, 32'(host_addr_bit15));
        chk("rx", 32'h0, 32'(rx));
        chk("tx", 32'h2, 32'({line_oe[3], line_out[3]}));
        ext_val <= 10'h004;
        tx      <= 1'b1;
        tick(5);
        chk("haddr", 32'h0, 32'(host_addr_bit15));
        chk("rx", 32'h1, 32'(rx));
        chk("tx", 32'h3, 32'({line_oe[3], line_out[3]}));
        ext_val <= 10'h001;
        bus_wr(REG_MODE, 32'h0);
        bus_wr(REG_ALT, 32'h0);
        tick(5);
        chk("haddr off", 32'h0, 32'(host_addr_bit15));
        chk("tx off", 32'h0, 32'(line_oe[3]));
        ext_en  <= 10'h0;
    endtask
    task automatic t_irq();
        for (int ch = 0; ch < 2; ch++)
        begin
            for (int s = 0; s < 5; s++)
            begin
                v0 = (s == SNS_FALL || s == SNS_LOW);
                ext_en[4+ch]  <= 1'b1;
                ext_val[4+ch] <= v0;
                bus_wr(REG_ALT, 32'h10 << ch);
                bus_wr(REG_IRQ_CFG, (32'(s) << (3 * ch)) | (32'h100 << ch));
                tick(5);
                bus_wr(REG_PEND, 32'h3);
                bus_rd(REG_PEND, 32'h0, "pend idle");
                chk("ack idle", 32'h2, 32'({line_oe[6+ch], line_out[6+ch]}));
                ext_val[4+ch] <= ~v0;
                tick(5);
                bus_rd(REG_PEND, 32'h1 << ch, "pend");
                chk("irq", 32'h1 << ch, 32'(irq));
                chk("ack", 32'h3, 32'({line_oe[6+ch], line_out[6+ch]}));
                ext_val[4+ch] <= v0;
                tick(5);
                bus_rd(REG_PEND, 32'h1 << ch, "pend held");
            end
        end
        bus_wr(REG_IRQ_CFG, 32'h0);
        bus_wr(REG_ALT, 32'h0);
        ext_val <= 10'h0;
        tick(5);
        bus_wr(REG_PEND, 32'h3);
        ext_val <= 10'h010;
        tick(5);
        bus_rd(REG_PEND, 32'h0, "unused irq");
        bus_rd(REG_PIN, 32'h3DF, "plain line");
        ext_en <= 10'h0;
    endtask
    task automatic t_wait_stop();
        bus_wr(REG_DIR, 32'h00F);
        bus_wr(REG_OUT, 32'h0);
        bus_wr(REG_ALT, 32'h300);
        wait_req <= 1'b1;
        tick(5);
        chk("hold", 32'h1, 32'(hold));
        wait_req <= 1'b0;
        ext_en   <= 10'h200;
        ext_val  <= 10'h0;
        tick(5);
        chk("hold", 32'h0, 32'(hold));
        chk("stop", 32'h1, 32'(stop));
        bus_wr(REG_OUT, 32'h00F);
        tick(3);
        chk("frozen", 32'h0, 32'(line_out[3:0]));
        ext_en <= 10'h0;
        tick(5);
        chk("stop", 32'h0, 32'(stop));
        chk("awake", 32'hF, 32'(line_out[3:0]));
    endtask
    task automatic t_ring_clk();
        ring_seen = 0;
        ring_req <= 1'b1;
        tick(3);
        ring_req <= 1'b0;
        tick(5);
        chk("ring pulses", 32'h1, 32'(ring_seen));
        bus_rd(REG_STAT, 32'h1, "ring flag");
        bus_wr(REG_STAT, 32'h1);
        bus_rd(REG_STAT, 32'h0, "ring clear");
        #20 chk("clk buf", 32'h1, 32'(clk_buf));
        #50 chk("clk buf", 32'h0, 32'(clk_buf));
    endtask

    // Main sequence and watchdog
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, tx} = '0;
        {wait_req, ring_req, ext_val, ext_en} = '0;
        modem     = '0;
        error_cnt = 0;
        comparisons = 0;
        ring_seen = 0;
        rst_b_in  = 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        tick(1);
        t_reset();
        t_plain();
        t_ind();
        t_alt();
        t_irq();
        t_wait_stop();
        t_ring_clk();
        close_out();
    end
    initial
    begin
        repeat (6000) @(posedge ref_clk_in);
        error_cnt++;
        close_out();
    end
endmodule
